// >>> bench/dreo_master.sv
`timescale 1ns/10ps
module dreo_master (
	// Answer
	input wire logic i_clk,
	input wire logic i_ack,
	input wire logic i_abort,
	input wire logic [31:0] i_code,
	input wire logic [31:0] i_rdata,
	// Request
	output logic o_req = 1'b0,
	output logic o_write = 1'b0,
	output logic [15:0] o_index = 16'h0000,
	output logic [7:0] o_sub = 8'h00,
	output logic [31:0] o_wdata = 32'h0
);
	logic [31:0] rd;
	logic [31:0] code;
	logic ab;
	// One-cycle pulse; the acknowledge stands only in the next cycle
	task automatic access(input logic w, input logic [15:0] idx, input logic [7:0] sub,
		input logic [31:0] wd);
		@(posedge i_clk) #1;
		o_req = 1'b1;
		o_write = w;
		o_index = idx;
		o_sub = sub;
		o_wdata = wd;
		@(posedge i_clk) #1;
		o_req = 1'b0;
		o_wdata = ~wd;
		ab = i_ack ? i_abort : 1'bx;
		rd = i_rdata;
		code = i_code;
	endtask
endmodule

// >>> bench/dreo_props.sv
`timescale 1ns/10ps
module dreo_props (
	// Watched ports
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_req,
	input wire logic i_write,
	input wire logic [15:0] i_index,
	input wire logic [7:0] i_subindex,
	input wire logic [31:0] i_wdata,
	input wire logic o_abort,
	input wire logic [31:0] o_abort_code,
	input wire logic [31:0] o_rdata,
	input wire logic i_profile_fault,
	input wire logic i_wrong_direction,
	input wire logic i_err_valid,
	input wire logic [7:0] o_fault_category_flags,
	input wire logic [7:0] o_fault_history_count
);
	wire rd = i_req && !i_write;
	wire wr = i_req && i_write;
	wire hist = i_index == 16'h1003;
	wire [7:0] fl = o_fault_category_flags;
	wire [7:0] cnt = o_fault_history_count;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	property p_type; rd && i_index == 16'h1000 && i_subindex == 8'h00
		|=> o_rdata == 32'h00020a5a; endproperty
	a_type: assert property (p_type) else $error("type word");
	property p_bit6; fl[6] == 1'b0; endproperty
	a_bit6: assert property (p_bit6) else $error("bit 6 set");
	// Guarded so the reset-time input is not compared
	property p_profile_fault_flag; $past(i_rst_n) |-> fl[5] == $past(i_profile_fault); endproperty
	a_profile_fault_flag: assert property (p_profile_fault_flag) else $error("profile flag");
	property p_dir; i_wrong_direction |=> fl[7]; endproperty
	a_dir: assert property (p_dir) else $error("direction flag");
	property p_self; $fell(i_wrong_direction) |=> !fl[7]; endproperty
	a_self: assert property (p_self) else $error("flag stuck");
	property p_push; i_err_valid && cnt < 8'h08 && !(wr && hist) |=> cnt == $past(cnt) + 8'h01;
	endproperty
	a_push: assert property (p_push) else $error("count step");
	property p_zero; wr && hist && i_subindex == 8'h00 && i_wdata == 32'h0 && !i_err_valid
		|=> cnt == 8'h00 && !o_abort; endproperty
	a_zero: assert property (p_zero) else $error("count restart");
	property p_empty; rd && hist && i_subindex inside {[8'h01:8'h08]} && cnt == 8'h00
		|=> o_abort && o_abort_code == 32'h08000024; endproperty
	a_empty: assert property (p_empty) else $error("empty read");
endmodule
bind dreo_top dreo_props u_props (.i_clk, .i_rst_n, .i_req, .i_write, .i_index, .i_subindex,
	.i_wdata, .o_abort, .o_abort_code, .o_rdata, .i_profile_fault, .i_wrong_direction,
	.i_err_valid, .o_fault_category_flags, .o_fault_history_count);

// >>> bench/testbench.sv
`timescale 1ns/10ps
module testbench;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] flt = 8'h00;
	logic err_v = 1'b0;
	logic [7:0] err_num = 8'h00;
	logic [15:0] err_code = 16'h0000;
	logic req, wr, ack, ab;
	logic [15:0] idx;
	logic [7:0] sub, flags, count;
	logic [31:0] wd, code, rdata;
	int checks = 0;
	int num_errors = 0;
	int cyc = 0;
	initial begin
		forever #10 clk = ~clk;
	end
	dreo_master m (.i_clk(clk), .i_ack(ack), .i_abort(ab), .i_code(code), .i_rdata(rdata),
		.o_req(req), .o_write(wr), .o_index(idx), .o_sub(sub), .o_wdata(wd));
	dreo_top DUT (.i_clk(clk), .i_rst_n(rst_n), .i_req(req), .i_write(wr), .i_index(idx),
		.i_subindex(sub), .i_wdata(wd), .o_ack(ack), .o_abort(ab), .o_abort_code(code),
		.o_rdata(rdata), .i_general_fault(flt[0]), .i_current_fault(flt[1]),
		.i_voltage_fault(flt[2]), .i_temperature_fault(flt[3]), .i_comms_fault(flt[4]),
		.i_profile_fault(flt[5]), .i_wrong_direction(flt[7]), .i_err_valid(err_v),
		.i_err_number(err_num), .i_err_code(err_code), .o_fault_category_flags(flags),
		.o_fault_history_count(count));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Any nonzero code means a refusal
	task automatic ex(input logic w, input logic [15:0] i, input logic [7:0] s,
		input logic [31:0] d, input logic [31:0] er, input logic [31:0] ec);
		m.access(w, i, s, d);
		chk(m.rd, er);
		chk(m.code, ec);
		chk({31'h0, m.ab}, {31'h0, ec != 32'h0});
	endtask
	task automatic results();
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			num_errors++;
			results();
		end
	end
	initial begin
		repeat (6) @(posedge clk);
		#1 rst_n = 1'b1;
		ex(1'b0, 16'h1000, 8'h00, 32'h0, 32'h00020a5a, 32'h0);
		ex(1'b1, 16'h1000, 8'h00, 32'h1, 32'h0, 32'h0a000003);
		ex(1'b0, 16'h1003, 8'h00, 32'h0, 32'h0, 32'h0);
		ex(1'b0, 16'h1003, 8'h08, 32'h0, 32'h0, 32'h08000024);
		$display("test reset done");
		flt = 8'hff;
		@(posedge clk) #1;
		chk({24'h0, flags}, 32'hbf);
		ex(1'b0, 16'h1001, 8'h00, 32'h0, 32'hbf, 32'h0);
		ex(1'b1, 16'h1001, 8'h00, 32'h0, 32'h0, 32'h0a000003);
		flt = 8'h00;
		@(posedge clk) #1;
		chk({24'h0, flags}, 32'h0);
		$display("test flags done");
		flt = 8'h21;
		for (int n = 1; n <= 9; n++) begin
			err_v = 1'b1;
			err_num = 8'(n);
			err_code = 16'h1000 + 16'(n);
			@(posedge clk) #1;
		end
		err_v = 1'b0;
		flt = 8'h00;
		chk({24'h0, count}, 32'h8);
		for (int k = 1; k <= 8; k++) begin
			ex(1'b0, 16'h1003, 8'(k), 32'h0, {8'(10 - k), 8'h21, 16'h1000 + 16'(10 - k)}, 0);
		end
		ex(1'b1, 16'h1003, 8'h00, 32'h5, 32'h0, 32'h0a000004);
		chk({24'h0, count}, 32'h8);
		ex(1'b1, 16'h1003, 8'h01, 32'h0, 32'h0, 32'h0a000003);
		ex(1'b1, 16'h1003, 8'h00, 32'h0, 32'h0, 32'h0);
		chk({24'h0, count}, 32'h0);
		ex(1'b0, 16'h1003, 8'h01, 32'h0, 32'h0, 32'h08000024);
		ex(1'b0, 16'h1003, 8'h09, 32'h0, 32'h0, 32'h0a000002);
		ex(1'b0, 16'h1001, 8'h01, 32'h0, 32'h0, 32'h0a000002);
		flt = 8'h80;
		err_v = 1'b1;
		err_num = 8'h0c;
		err_code = 16'h4000;
		@(posedge clk) #1;
		err_v = 1'b0;
		flt = 8'h00;
		chk({24'h0, count}, 32'h1);
		ex(1'b0, 16'h1003, 8'h01, 32'h0, 32'h0c804000, 32'h0);
		$display("test history done");
		rst_n = 1'b0;
		@(posedge clk) #1;
		rst_n = 1'b1;
		chk({24'h0, count}, 32'h0);
		chk({24'h0, flags}, 32'h0);
		err_v = 1'b1;
		err_num = 8'h05;
		err_code = 16'h1000;
		@(posedge clk) #1;
		err_v = 1'b0;
		chk({24'h0, count}, 32'h1);
		ex(1'b0, 16'h1003, 8'h02, 32'h0, 32'h0, 32'h0);
		$display("test reset again done");
		results();
	end
endmodule

// >>> pkg/dreo_hist_if.sv
`timescale 1ns/10ps
`include "dreo_regs.svh"
interface dreo_hist_if;
	logic push;
	dreo_pkg::dreo_entry_t new_entry;
	logic clear;
	dreo_pkg::dreo_byte_t count;
	dreo_pkg::dreo_entry_t entry [`DREO_HIST_DEPTH];

	modport stack (
		input push,
		input new_entry,
		input clear,
		output count,
		output entry
	);
	modport user (
		output push,
		output new_entry,
		output clear,
		input count,
		input entry
	);
endinterface

// >>> pkg/dreo_pkg.sv
package dreo_pkg;
	typedef logic [31:0] dreo_word_t;
	typedef logic [7:0] dreo_byte_t;
	typedef struct packed {
		logic [7:0] number;
		logic [7:0] category;
		logic [15:0] code;
	} dreo_entry_t;
endpackage

// >>> pkg/dreo_regs.svh
`ifndef DREO_REGS_SVH
`define DREO_REGS_SVH

// Object indices and subindices
`define DREO_IDX_TYPE 16'h1000
`define DREO_IDX_FLAGS 16'h1001
`define DREO_IDX_HIST 16'h1003
`define DREO_SUB_ZERO 8'h00
`define DREO_SUB_FIRST 8'h01
`define DREO_HIST_DEPTH 8
`define DREO_HIST_LAST 8'h08

// Controller type word fields
`define DREO_MOTOR_SERVO 8'h01
`define DREO_MOTOR_STEPPER 8'h02
`define DREO_TYPE_TOP 8'h00

// Category flag bit positions
`define DREO_BIT_GENERAL 0
`define DREO_BIT_CURRENT 1
`define DREO_BIT_VOLTAGE 2
`define DREO_BIT_TEMP 3
`define DREO_BIT_COMMS 4
`define DREO_BIT_PROFILE 5
`define DREO_BIT_UNUSED 6
`define DREO_BIT_WRONG_DIR 7

// Reset values
`define DREO_FLAGS_RESET 8'h00
`define DREO_COUNT_RESET 8'h00
`define DREO_WORD_RESET 32'h00000000
`define DREO_COUNT_PAD 24'h000000

// Abort codes
`define DREO_ABORT_NONE 32'h00000000
`define DREO_ABORT_EMPTY 32'h08000024
`define DREO_ABORT_NO_OBJ 32'h0a000001
`define DREO_ABORT_NO_SUB 32'h0a000002
`define DREO_ABORT_READ_ONLY 32'h0a000003
`define DREO_ABORT_VALUE 32'h0a000004
`endif

// >>> verilog/dreo_history.sv
`timescale 1ns/10ps
`include "dreo_regs.svh"
module dreo_history #(
	parameter int DEPTH = `DREO_HIST_DEPTH
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Stack access
	dreo_hist_if.stack hist
);
	// Stack lives here; the interface only carries a read view of it
	dreo_pkg::dreo_entry_t slots [DEPTH];

	// Newest entry at slot 0, oldest falls off the end
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			slots[0] <= `DREO_WORD_RESET;
		end else if (hist.push) begin
			slots[0] <= hist.new_entry;
		end
	end

	genvar k;
	generate
		for (k = 1; k < DEPTH; k++) begin : g_slot
			always_ff @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					slots[k] <= `DREO_WORD_RESET;
				end else if (hist.push) begin
					slots[k] <= slots[k-1];
				end
			end
		end
		for (k = 0; k < DEPTH; k++) begin : g_view
			assign hist.entry[k] = slots[k];
		end
	endgenerate

	// A push in the same cycle as a clear still counts
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			hist.count <= `DREO_COUNT_RESET;
		end else if (hist.push && hist.clear) begin
			hist.count <= `DREO_SUB_FIRST;
		end else if (hist.push) begin
			if (hist.count < 8'(DEPTH)) begin
				hist.count <= hist.count + `DREO_SUB_FIRST;
			end
		end else if (hist.clear) begin
			hist.count <= `DREO_COUNT_RESET;
		end
	end
endmodule

// >>> verilog/dreo_top.sv
`timescale 1ns/10ps
`include "dreo_regs.svh"
module dreo_top #(
	parameter logic [7:0] MOTOR_TYPE = `DREO_MOTOR_STEPPER,
	// Arbitrary value, set to the supported profile number at integration
	parameter logic [15:0] PROFILE_NUMBER = 16'h0a5a
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Object access
	input wire logic i_req,
	input wire logic i_write,
	input wire logic [15:0] i_index,
	input wire logic [7:0] i_subindex,
	input wire logic [31:0] i_wdata,
	output logic o_ack,
	output logic o_abort,
	output logic [31:0] o_abort_code,
	output logic [31:0] o_rdata,
	// Fault condition levels, same clock
	input wire logic i_general_fault,
	input wire logic i_current_fault,
	input wire logic i_voltage_fault,
	input wire logic i_temperature_fault,
	input wire logic i_comms_fault,
	input wire logic i_profile_fault,
	input wire logic i_wrong_direction,
	// Error event
	input wire logic i_err_valid,
	input wire logic [7:0] i_err_number,
	input wire logic [15:0] i_err_code,
	// Cyclic transmit data
	output logic [7:0] o_fault_category_flags,
	output logic [7:0] o_fault_history_count
);
	dreo_hist_if hist();

	dreo_pkg::dreo_word_t controller_type_word;
	dreo_pkg::dreo_byte_t fault_category_flags;
	dreo_pkg::dreo_byte_t next_flags;
	logic next_abort;
	dreo_pkg::dreo_word_t next_abort_code;
	dreo_pkg::dreo_word_t next_rdata;
	logic next_clear;
	logic [2:0] slot;
	// Request decodes for the history object
	logic hist_empty;
	logic zero_write;
	logic entry_sub;

	function automatic logic is_entry_sub(input logic [7:0] sub);
		is_entry_sub = (sub >= `DREO_SUB_FIRST) && (sub <= `DREO_HIST_LAST);
	endfunction

	// Byte objects read back in the low byte, upper bits zero
	function automatic logic [31:0] pad_byte(input logic [7:0] value);
		pad_byte = {`DREO_COUNT_PAD, value};
	endfunction

	// Constant word, no storage so nothing can alter it
	assign controller_type_word = {`DREO_TYPE_TOP, MOTOR_TYPE, PROFILE_NUMBER};

	// Flags follow the live fault levels, so they drop without any clear
	always_comb begin
		next_flags = `DREO_FLAGS_RESET;
		next_flags[`DREO_BIT_GENERAL] = i_general_fault;
		next_flags[`DREO_BIT_CURRENT] = i_current_fault;
		next_flags[`DREO_BIT_VOLTAGE] = i_voltage_fault;
		next_flags[`DREO_BIT_TEMP] = i_temperature_fault;
		next_flags[`DREO_BIT_COMMS] = i_comms_fault;
		next_flags[`DREO_BIT_PROFILE] = i_profile_fault;
		next_flags[`DREO_BIT_UNUSED] = 1'b0;
		next_flags[`DREO_BIT_WRONG_DIR] = i_wrong_direction;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			fault_category_flags <= `DREO_FLAGS_RESET;
		end else begin
			fault_category_flags <= next_flags;
		end
	end

	assign o_fault_category_flags = fault_category_flags;
	assign o_fault_history_count = hist.count;

	// Class byte takes the flags as they stand with the error itself
	assign hist.push = i_err_valid;
	assign hist.new_entry = '{number: i_err_number, category: next_flags, code: i_err_code};
	assign hist.clear = next_clear;

	// Subindex 0 wraps here, but is never used as a slot
	assign slot = 3'(i_subindex - `DREO_SUB_FIRST);

	// Empty stack refuses every entry read, stored or not
	assign hist_empty = hist.count == `DREO_COUNT_RESET;
	assign entry_sub = is_entry_sub(i_subindex);
	assign zero_write = i_write && (i_wdata == `DREO_WORD_RESET);

	// Object decode, one answer per request
	always_comb begin
		next_abort = 1'b0;
		next_abort_code = `DREO_ABORT_NONE;
		next_rdata = `DREO_WORD_RESET;
		next_clear = 1'b0;
		unique case (i_index)
			`DREO_IDX_TYPE: begin
				if (i_subindex != `DREO_SUB_ZERO) begin
					next_abort = 1'b1;
					next_abort_code = `DREO_ABORT_NO_SUB;
				end else if (i_write) begin
					next_abort = 1'b1;
					next_abort_code = `DREO_ABORT_READ_ONLY;
				end else begin
					next_rdata = controller_type_word;
				end
			end
			`DREO_IDX_FLAGS: begin
				if (i_subindex != `DREO_SUB_ZERO) begin
					next_abort = 1'b1;
					next_abort_code = `DREO_ABORT_NO_SUB;
				end else if (i_write) begin
					next_abort = 1'b1;
					next_abort_code = `DREO_ABORT_READ_ONLY;
				end else begin
					next_rdata = pad_byte(fault_category_flags);
				end
			end
			`DREO_IDX_HIST: begin
				if (i_subindex == `DREO_SUB_ZERO) begin
					if (!i_write) begin
						next_rdata = pad_byte(hist.count);
					end else if (zero_write) begin
						next_clear = i_req;
					end else begin
						// Only zero is a legal count write
						next_abort = 1'b1;
						next_abort_code = `DREO_ABORT_VALUE;
					end
				end else if (!entry_sub) begin
					next_abort = 1'b1;
					next_abort_code = `DREO_ABORT_NO_SUB;
				end else if (i_write) begin
					next_abort = 1'b1;
					next_abort_code = `DREO_ABORT_READ_ONLY;
				end else if (hist_empty) begin
					next_abort = 1'b1;
					next_abort_code = `DREO_ABORT_EMPTY;
				end else begin
					next_rdata = hist.entry[slot];
				end
			end
			default: begin
				next_abort = 1'b1;
				next_abort_code = `DREO_ABORT_NO_OBJ;
			end
		endcase
	end

	// Acknowledge one cycle after the request, high for that one cycle only
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_ack <= 1'b0;
		end else begin
			o_ack <= i_req;
		end
	end

	// Refusal flag, held until the next request
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_abort <= 1'b0;
		end else if (i_req) begin
			o_abort <= next_abort;
		end
	end

	// Refusal code, zero on a granted access
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_abort_code <= `DREO_ABORT_NONE;
		end else if (i_req) begin
			o_abort_code <= next_abort_code;
		end
	end

	// Read data, zero on writes and refusals
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= `DREO_WORD_RESET;
		end else if (i_req) begin
			o_rdata <= next_rdata;
		end
	end

	dreo_history #(
		.DEPTH(`DREO_HIST_DEPTH)
	) u_history (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.hist(hist.stack)
	);
endmodule
